// >>> design/srs_regbank.sv
// Sensor register bank with two-wire and SPI slave front ends.
// Assumes a measurement engine on I_SYS_CLK and a host on the serial pins.
//
// How it works
// - Setpoint field picks one of ten heater profiles.
// - Gas conversions start only with run enable.
// - Result registers are shadowed against concurrent reads.
// - Pressure spread over three bytes, MSB first.
// - Temperature spread over three bytes, MSB first.
// - Humidity as high byte then low byte.
// - Gas resistance bits 9:2 then 1:0.
// - Gas low byte carries ADC range code.
// - Phase end loads results and sets new-data.
// - Gas measuring flag until gas result loaded.
// - Measuring flag until all results loaded.
// - Status holds gas index zero to nine.
// - Gas valid bit marks a real gas slot.
// - Heater stability bit in gas low byte.
// - Single, paired, and auto-increment burst accesses.
// - SPI modes 00 and 11, four and three wire.
// - Chip-select level picks two-wire or SPI.
// - Chip-select low once disables two-wire until reset.
// - Two-wire slave never stretches the clock.
// - Two-wire address 111011 plus live pin bit.
// - Skipped pressure or temperature reads 0x80000.
`include "srs_regs.svh"
`timescale 1ns/100ps
`default_nettype none

module srs_regbank
(
  input  wire logic        I_SYS_CLK,
  input  wire logic        I_RESETN,
  input  wire logic        I_SCK,
  input  wire logic        I_CHIP_SELECT_N,
  input  wire logic        I_SERIAL_IN_PIN,
  input  wire logic        I_SERIAL_OUT_ADDR_LSB_PIN,
  input  wire logic        I_MEAS_BUSY,
  input  wire logic        I_GAS_BUSY,
  input  wire logic        I_GAS_SLOT,
  input  wire logic        I_PHASE_DONE,
  input  wire logic        I_PRESS_SKIP,
  input  wire logic        I_TEMP_SKIP,
  input  wire logic [19:0] I_PRESS_RAW,
  input  wire logic [19:0] I_TEMP_RAW,
  input  wire logic [15:0] I_HUM_RAW,
  input  wire logic [9:0]  I_GAS_RAW,
  input  wire logic [3:0]  I_GAS_RANGE,
  input  wire logic        I_HEAT_STAB,
  output logic      [3:0]  O_HEATER_SETPOINT_SELECT,
  output logic             O_GAS_RUN_EN,
  output logic             O_GAS_CONV_START,
  output logic             O_SERIAL_IN_PIN_I2C_OE,
  output logic             O_SERIAL_IN_PIN_SPI_O,
  output logic             O_SERIAL_IN_PIN_SPI_OE,
  output logic             O_SERIAL_OUT_ADDR_LSB_PIN_O,
  output logic             O_SERIAL_OUT_ADDR_LSB_PIN_OE
);

  // ---------------------------------------------------------------
  // Register read map
  // ---------------------------------------------------------------
  srs_pkg::srs_result_t vis_q, vis_d, pend_q, pend_d, nres;
  logic [7:0] stat_q, stat_d;
  logic [4:0] ctl_q, ctl_d;
  logic       w3_q, w3_d;

  function automatic logic [7:0] rd_byte(input logic [7:0] a);
    unique case (a)
      `SRS_OFS_STATUS:  rd_byte = stat_q;
      `SRS_OFS_PRESS_H: rd_byte = vis_q.press[19:12];
      `SRS_OFS_PRESS_M: rd_byte = vis_q.press[11:4];
      `SRS_OFS_PRESS_L: rd_byte = {vis_q.press[3:0], 4'h0};
      `SRS_OFS_TEMP_H:  rd_byte = vis_q.temp[19:12];
      `SRS_OFS_TEMP_M:  rd_byte = vis_q.temp[11:4];
      `SRS_OFS_TEMP_L:  rd_byte = {vis_q.temp[3:0], 4'h0};
      `SRS_OFS_HUM_H:   rd_byte = vis_q.hum[15:8];
      `SRS_OFS_HUM_L:   rd_byte = vis_q.hum[7:0];
      `SRS_OFS_GAS_H:   rd_byte = vis_q.gas[9:2];
      `SRS_OFS_GAS_L:   rd_byte = {vis_q.gas[1:0], vis_q.valid, vis_q.stab,
                                   vis_q.range};
      `SRS_OFS_GAS_CTL: rd_byte = {3'h0, ctl_q};
      `SRS_OFS_SPI3W:   rd_byte = {7'h00, w3_q};
      default:          rd_byte = 8'h00;
    endcase
  endfunction : rd_byte

  // ---------------------------------------------------------------
  // Pin synchronisers on the system clock
  // ---------------------------------------------------------------
  logic csb_m, csb_s, scl_m, scl_s, scl_p, sda_m, sda_s, sda_p;
  logic lsb_m, lsb_s, wtg_m, wtg_s, wtg_p;
  logic wtg_q;
  logic [7:0] swa_q, swd_q;

  always_ff @(posedge I_SYS_CLK or negedge I_RESETN)
  begin
    if (!I_RESETN)
    begin
      {csb_m, csb_s, scl_m, scl_s, scl_p} <= 5'h1F;
      {sda_m, sda_s, sda_p, lsb_m, lsb_s} <= 5'h1C;
      {wtg_m, wtg_s, wtg_p} <= 3'h0;
    end
    else
    begin
      {csb_m, csb_s} <= {I_CHIP_SELECT_N, csb_m};
      {scl_m, scl_s, scl_p} <= {I_SCK, scl_m, scl_s};
      {sda_m, sda_s, sda_p} <= {I_SERIAL_IN_PIN, sda_m, sda_s};
      {lsb_m, lsb_s} <= {I_SERIAL_OUT_ADDR_LSB_PIN, lsb_m};
      {wtg_m, wtg_s, wtg_p} <= {wtg_q, wtg_m, wtg_s};
    end
  end

  // ---------------------------------------------------------------
  // Bus selection lock
  // ---------------------------------------------------------------
  // Only a low I_RESETN clears the lock, so a short chip-select
  // pulse meant for another SPI slave still retires the two-wire bus.
  logic lock_q, lock_d, i2c_en;
  always_comb
  begin
    lock_d = lock_q | ~csb_s;
  end
  always_ff @(posedge I_SYS_CLK or negedge I_RESETN)
  begin
    if (!I_RESETN)
      lock_q <= 1'b0;
    else
      lock_q <= lock_d;
  end
  assign i2c_en = ~lock_q & csb_s;

  // ---------------------------------------------------------------
  // Two-wire slave, oversampled on the system clock
  // ---------------------------------------------------------------
  // The clock line is only ever read, so no stretching is possible;
  // high-speed mode needs the system clock well above eight times SCL.
  srs_pkg::srs_i2c_st_t st_q, st_d;
  logic [2:0] bit_q, bit_d;
  logic [7:0] sh_q, sh_d, ptr_q, ptr_d, ib, rb;
  logic oe_q, oe_d, rw_q, rw_d, hp_q, hp_d, bsy_q, bsy_d;
  logic i_wr, rise, fall, start, stop;

  always_comb
  begin
    rise  = scl_s & ~scl_p;
    fall  = ~scl_s & scl_p;
    start = scl_s & scl_p & sda_p & ~sda_s;
    stop  = scl_s & scl_p & ~sda_p & sda_s;
    ib    = {sh_q[6:0], sda_s};
    rb    = rd_byte(ptr_q);
    st_d  = st_q;
    bit_d = bit_q;
    sh_d  = sh_q;
    ptr_d = ptr_q;
    oe_d  = oe_q;
    rw_d  = rw_q;
    hp_d  = hp_q;
    bsy_d = bsy_q;
    i_wr  = 1'b0;
    if (!i2c_en || stop)
    begin
      st_d  = srs_pkg::SRS_IDLE;
      oe_d  = 1'b0;
      bsy_d = 1'b0;
    end
    else if (start)
    begin
      st_d  = srs_pkg::SRS_ADDR;
      bit_d = 3'h0;
      oe_d  = 1'b0;
      hp_d  = 1'b0;
      bsy_d = 1'b1;
    end
    else
    begin
      unique case (st_q)
        srs_pkg::SRS_IDLE: ;
        srs_pkg::SRS_ADDR:
          if (rise)
          begin
            sh_d  = ib;
            bit_d = bit_q + 3'h1;
            if (bit_q == 3'h7)
            begin
              rw_d = ib[0];
              if (ib[7:2] == `SRS_I2C_HI6 && ib[1] == lsb_s)
                st_d = srs_pkg::SRS_ACK;
              else
                st_d = srs_pkg::SRS_IDLE;
            end
          end
        srs_pkg::SRS_ACK:
          if (fall)
          begin
            bit_d = 3'h0;
            if (!oe_q)
              oe_d = 1'b1;
            else if (rw_q)
            begin
              sh_d = rb;
              oe_d = ~rb[7];
              st_d = srs_pkg::SRS_RBYTE;
            end
            else
            begin
              oe_d = 1'b0;
              st_d = srs_pkg::SRS_WBYTE;
            end
          end
        srs_pkg::SRS_WBYTE:
          if (rise)
          begin
            sh_d  = ib;
            bit_d = bit_q + 3'h1;
            if (bit_q == 3'h7)
            begin
              // Bytes after the device address alternate register
              // address and data, so a long write is a list of pairs.
              hp_d = ~hp_q;
              i_wr = hp_q;
              if (!hp_q)
                ptr_d = ib;
              st_d = srs_pkg::SRS_ACK;
            end
          end
        srs_pkg::SRS_RBYTE:
          if (fall)
          begin
            if (bit_q == 3'h7)
            begin
              oe_d  = 1'b0;
              ptr_d = ptr_q + 8'h01;
              st_d  = srs_pkg::SRS_RACK;
            end
            else
            begin
              sh_d  = {sh_q[6:0], 1'b0};
              oe_d  = ~sh_q[6];
              bit_d = bit_q + 3'h1;
            end
          end
        srs_pkg::SRS_RACK:
          if (rise)
            hp_d = ~sda_s;
          else if (fall)
          begin
            bit_d = 3'h0;
            if (hp_q)
            begin
              sh_d = rb;
              oe_d = ~rb[7];
              st_d = srs_pkg::SRS_RBYTE;
            end
            else
              st_d = srs_pkg::SRS_IDLE;
          end
        default:
          st_d = srs_pkg::SRS_IDLE;
      endcase
    end
  end

  always_ff @(posedge I_SYS_CLK or negedge I_RESETN)
  begin
    if (!I_RESETN)
    begin
      st_q  <= srs_pkg::SRS_IDLE;
      bit_q <= 3'h0;
      sh_q  <= 8'h00;
      ptr_q <= 8'h00;
      oe_q  <= 1'b0;
      rw_q  <= 1'b0;
      hp_q  <= 1'b0;
      bsy_q <= 1'b0;
    end
    else
    begin
      st_q  <= st_d;
      bit_q <= bit_d;
      sh_q  <= sh_d;
      ptr_q <= ptr_d;
      oe_q  <= oe_d;
      rw_q  <= rw_d;
      hp_q  <= hp_d;
      bsy_q <= bsy_d;
    end
  end

  // ---------------------------------------------------------------
  // Control registers and measurement results
  // ---------------------------------------------------------------
  logic frz, ld, s_wr, w_en, gv_q, gv_d, gs_q, gs_d;
  logic [3:0] gi_q, gi_d;
  logic [7:0] w_adr, w_dat;
  logic pf_q, pf_d, mb_q, mb_d, gm_q, gm_d, nd_q, nd_d, bp_q;

  always_comb
  begin
    // A host transfer freezes the visible copy for its whole length.
    frz   = bsy_q | ~csb_s;
    s_wr  = wtg_s ^ wtg_p;
    w_en  = i_wr | s_wr;
    w_adr = i_wr ? ptr_q : swa_q;
    w_dat = i_wr ? ib : swd_q;
    ctl_d = ctl_q;
    w3_d  = w3_q;
    if (w_en && w_adr == `SRS_OFS_GAS_CTL)
    begin
      ctl_d[`SRS_RUN_BIT] = w_dat[`SRS_RUN_BIT];
      ctl_d[3:0] = (w_dat[3:0] > `SRS_SETPT_MAX) ? `SRS_SETPT_MAX
                                                  : w_dat[3:0];
    end
    if (w_en && w_adr == `SRS_OFS_SPI3W)
      w3_d = w_dat[0];
    gs_d = I_GAS_SLOT & ctl_q[`SRS_RUN_BIT];
    gv_d = I_GAS_SLOT ? ctl_q[`SRS_RUN_BIT] : gv_q;
    gi_d = I_GAS_SLOT ? ctl_q[3:0] : gi_q;
    nres.press = I_PRESS_SKIP ? `SRS_SKIP_VALUE : I_PRESS_RAW;
    nres.temp  = I_TEMP_SKIP ? `SRS_SKIP_VALUE : I_TEMP_RAW;
    nres.hum   = I_HUM_RAW;
    nres.gas   = I_GAS_RAW;
    nres.range = I_GAS_RANGE;
    nres.valid = gv_q;
    nres.stab  = I_HEAT_STAB;
    nres.idx   = gi_q;
    vis_d  = vis_q;
    pend_d = pend_q;
    pf_d   = pf_q;
    ld     = 1'b0;
    if (I_PHASE_DONE && frz)
    begin
      pend_d = nres;
      pf_d   = 1'b1;
    end
    else if (I_PHASE_DONE)
    begin
      vis_d = nres;
      pf_d  = 1'b0;
      ld    = 1'b1;
    end
    else if (pf_q && !frz)
    begin
      vis_d = pend_q;
      pf_d  = 1'b0;
      ld    = 1'b1;
    end
    mb_d = I_MEAS_BUSY | (mb_q & ~ld);
    gm_d = I_GAS_BUSY | (gm_q & ~ld);
    // A load wins over the clear at the start of the next measurement.
    nd_d = ld | (nd_q & ~(I_MEAS_BUSY & ~bp_q));
    stat_d = frz ? stat_q : {nd_q, gm_q, mb_q, 1'b0, vis_q.idx};
  end

  always_ff @(posedge I_SYS_CLK or negedge I_RESETN)
  begin
    if (!I_RESETN)
    begin
      ctl_q  <= `SRS_CTL_RESET;
      w3_q   <= 1'b0;
      gs_q   <= 1'b0;
      gv_q   <= 1'b0;
      gi_q   <= 4'h0;
      vis_q  <= '0;
      pend_q <= '0;
      pf_q   <= 1'b0;
      mb_q   <= 1'b0;
      gm_q   <= 1'b0;
      nd_q   <= 1'b0;
      bp_q   <= 1'b0;
      stat_q <= 8'h00;
    end
    else
    begin
      ctl_q  <= ctl_d;
      w3_q   <= w3_d;
      gs_q   <= gs_d;
      gv_q   <= gv_d;
      gi_q   <= gi_d;
      vis_q  <= vis_d;
      pend_q <= pend_d;
      pf_q   <= pf_d;
      mb_q   <= mb_d;
      gm_q   <= gm_d;
      nd_q   <= nd_d;
      bp_q   <= I_MEAS_BUSY;
      stat_q <= stat_d;
    end
  end

  assign O_HEATER_SETPOINT_SELECT = ctl_q[3:0];
  assign O_GAS_RUN_EN             = ctl_q[`SRS_RUN_BIT];
  assign O_GAS_CONV_START         = gs_q;
  assign O_SERIAL_IN_PIN_I2C_OE   = oe_q;

  // ---------------------------------------------------------------
  // SPI slave on the serial clock
  // ---------------------------------------------------------------
  // Sampling on the rising edge and driving on the falling edge serves
  // modes 00 and 11 alike. Raising chip-select ends the frame at once.
  logic frst_n, cd_q, cd_d, rd_q, rd_d, w3m, w3s;
  logic [2:0] cnt_q, cnt_d;
  logic [7:0] ss_q, ss_d, sb, so_q, so_d, swa_d, swd_d;
  logic [6:0] sa_q, sa_d;
  logic wtg_d, oo_q, oo_d, oi_q, oi_d;

  assign frst_n = I_RESETN & ~I_CHIP_SELECT_N;

  always_comb
  begin
    sb    = {ss_q[6:0], I_SERIAL_IN_PIN};
    cnt_d = cnt_q + 3'h1;
    ss_d  = sb;
    sa_d  = sa_q;
    cd_d  = cd_q;
    rd_d  = rd_q;
    wtg_d = wtg_q;
    swa_d = swa_q;
    swd_d = swd_q;
    if (cnt_q == 3'h7)
    begin
      if (!cd_q)
      begin
        sa_d = sb[6:0];
        rd_d = sb[7];
        cd_d = 1'b1;
      end
      else if (rd_q)
        sa_d = sa_q + 7'h01;
      else
      begin
        swa_d = {1'b0, sa_q};
        swd_d = sb;
        wtg_d = ~wtg_q;
        cd_d  = 1'b0;
      end
    end
  end

  always_ff @(posedge I_SCK or negedge frst_n)
  begin
    if (!frst_n)
    begin
      cnt_q <= 3'h0;
      ss_q  <= 8'h00;
      sa_q  <= 7'h00;
      cd_q  <= 1'b0;
      rd_q  <= 1'b0;
    end
    else
    begin
      cnt_q <= cnt_d;
      ss_q  <= ss_d;
      sa_q  <= sa_d;
      cd_q  <= cd_d;
      rd_q  <= rd_d;
    end
  end

  // Write handoff survives the frame reset; words stay put until the
  // toggle has been seen, as the next write is sixteen edges away.
  always_ff @(posedge I_SCK or negedge I_RESETN)
  begin
    if (!I_RESETN)
    begin
      wtg_q <= 1'b0;
      swa_q <= 8'h00;
      swd_q <= 8'h00;
      w3m   <= 1'b0;
      w3s   <= 1'b0;
    end
    else
    begin
      wtg_q <= wtg_d;
      swa_q <= swa_d;
      swd_q <= swd_d;
      w3m   <= w3_q;
      w3s   <= w3m;
    end
  end

  always_comb
  begin
    so_d = {so_q[6:0], 1'b0};
    if (cd_q && rd_q && cnt_q == 3'h0)
      so_d = rd_byte({1'b0, sa_q});
    oo_d = cd_q & rd_q & ~w3s;
    oi_d = cd_q & rd_q & w3s;
  end

  always_ff @(negedge I_SCK or negedge frst_n)
  begin
    if (!frst_n)
    begin
      so_q <= 8'h00;
      oo_q <= 1'b0;
      oi_q <= 1'b0;
    end
    else
    begin
      so_q <= so_d;
      oo_q <= oo_d;
      oi_q <= oi_d;
    end
  end

  assign O_SERIAL_OUT_ADDR_LSB_PIN_O  = so_q[7];
  assign O_SERIAL_OUT_ADDR_LSB_PIN_OE = oo_q;
  assign O_SERIAL_IN_PIN_SPI_O        = so_q[7];
  assign O_SERIAL_IN_PIN_SPI_OE       = oi_q;

  // ---------------------------------------------------------------
  // Assertions on the system clock
  // ---------------------------------------------------------------
  default clocking cb @(posedge I_SYS_CLK); endclocking
  default disable iff (!I_RESETN);

  sequence s_held;
    pf_q && frz;
  endsequence
  sequence s_free;
    !frz && !I_PHASE_DONE;
  endsequence

  setpt_range_a: assert property (O_HEATER_SETPOINT_SELECT <= 4'h9)
    else $error("setpoint above nine");
  gas_gate_a: assert property (I_GAS_SLOT && !O_GAS_RUN_EN |=> !O_GAS_CONV_START)
    else $error("gas conversion started while disabled");
  shadow_hold_a: assert property (frz && $past(frz) |-> $stable(vis_q))
    else $error("visible results changed during a transfer");
  skip_value_a: assert property (I_PHASE_DONE && !frz && I_PRESS_SKIP
    |=> vis_q.press == 20'h80000)
    else $error("skipped pressure not loaded with marker");
  new_data_a: assert property (ld |=> nd_q)
    else $error("new data flag missing after load");
  gas_flag_a: assert property (ld && !I_GAS_BUSY |=> !gm_q)
    else $error("gas measuring flag stuck after load");
  meas_flag_a: assert property (I_MEAS_BUSY |=> mb_q ##1 (stat_q[5] || $past(frz)))
    else $error("measuring flag not shown");
  lock_keep_a: assert property (!csb_s ##1 1 |-> lock_q ##1 lock_q)
    else $error("bus lock released");
  i2c_off_a: assert property (lock_q |=> st_q == srs_pkg::SRS_IDLE && !oe_q)
    else $error("two-wire slave active after lock");
  pend_move_a: assert property (s_held ##1 s_free |=> !pf_q && vis_q == $past(pend_q))
    else $error("pending snapshot not released");

endmodule : srs_regbank
`default_nettype wire

// >>> design/srs_regs.svh
// Register offsets, field positions and reset values of the sensor register bank.
// Assumes inclusion by bare name from the top module.
`ifndef SRS_REGS_SVH
`define SRS_REGS_SVH
`define SRS_OFS_STATUS  8'h1D
`define SRS_OFS_PRESS_H 8'h1F
`define SRS_OFS_PRESS_M 8'h20
`define SRS_OFS_PRESS_L 8'h21
`define SRS_OFS_TEMP_H  8'h22
`define SRS_OFS_TEMP_M  8'h23
`define SRS_OFS_TEMP_L  8'h24
`define SRS_OFS_HUM_H   8'h25
`define SRS_OFS_HUM_L   8'h26
`define SRS_OFS_GAS_H   8'h2A
`define SRS_OFS_GAS_L   8'h2B
`define SRS_OFS_GAS_CTL 8'h71
`define SRS_OFS_SPI3W   8'h75
`define SRS_RUN_BIT     4
`define SRS_CTL_RESET   5'h00
`define SRS_SETPT_MAX   4'h9
`define SRS_SKIP_VALUE  20'h80000
`define SRS_I2C_HI6     6'h3B
`endif

// >>> design/srs_pkg.sv
// Types shared by the sensor register bank.
// Assumes nothing of its surroundings.
package srs_pkg;
  typedef struct packed
  {
    logic [19:0] press;
    logic [19:0] temp;
    logic [15:0] hum;
    logic [9:0]  gas;
    logic [3:0]  range;
    logic        valid;
    logic        stab;
    logic [3:0]  idx;
  } srs_result_t;

  typedef enum logic [2:0]
  {
    SRS_IDLE  = 3'h0,
    SRS_ADDR  = 3'h1,
    SRS_ACK   = 3'h3,
    SRS_WBYTE = 3'h2,
    SRS_RBYTE = 3'h6,
    SRS_RACK  = 3'h7
  } srs_i2c_st_t;
endpackage : srs_pkg

// >>> bench/srs_host.sv
// Host model: SPI and two-wire master on the sensor pins.
// Assumes the bench resolves each data pin from every driver's enable.
`timescale 1ns/100ps
`default_nettype none
module srs_host
(
  input  wire logic i_sdi,
  input  wire logic i_sdo,
  output logic      o_sck,
  output logic      o_csb_n,
  output logic      o_sdi,
  output logic      o_sdi_oe,
  output logic      o_sdo
);
  logic m11_q;

  // Chip-select starts high so that the two-wire bus is not locked out.
  initial
  begin
    m11_q    = 1'h0;
    o_sck    = 1'h1;
    o_csb_n  = 1'h1;
    o_sdi    = 1'h0;
    o_sdi_oe = 1'h0;
    o_sdo    = 1'h0;
  end

  // SCK rests at the mode's idle level, so it only runs inside frames.
  task automatic spi_begin(input logic m);
    m11_q    = m;
    o_sck    = m;
    #200;
    o_csb_n  = 1'h0;
    o_sdi_oe = 1'h1;
    #200;
  endtask : spi_begin

  task automatic spi_byte(input logic [7:0] w, output logic [7:0] r);
    for (int i = 7; i >= 0; i--)
    begin
      o_sck = 1'h0;
      o_sdi = w[i];
      #80;
      o_sck = 1'h1;
      r[i]  = i_sdo;
      // A released output pin shows the inverse of the last bit.
      o_sdo = ~i_sdo;
      #80;
    end
  endtask : spi_byte

  task automatic spi_end();
    o_sck    = m11_q;
    #200;
    o_csb_n  = 1'h1;
    o_sdi_oe = 1'h0;
    #400;
  endtask : spi_end

  // Address byte with write direction, then stop; ack is the ninth bit.
  task automatic i2c_addr(input logic [6:0] a, input logic pin, output logic ack);
    logic [8:0] b;
    b        = {a, 2'h1};
    o_sdo    = pin;
    o_sdi    = 1'h0;
    o_sck    = 1'h1;
    #200;
    o_sdi_oe = 1'h1;
    #80;
    for (int i = 8; i >= 0; i--)
    begin
      o_sck    = 1'h0;
      #60;
      o_sdi_oe = ~b[i];
      #80;
      o_sck    = 1'h1;
      ack      = (i_sdi === 1'h0);
      #80;
    end
    o_sck    = 1'h0;
    #60;
    o_sdi_oe = 1'h1;
    #80;
    o_sck    = 1'h1;
    #60;
    o_sdi_oe = 1'h0;
    #200;
  endtask : i2c_addr
endmodule : srs_host
`default_nettype wire

// >>> bench/tb_top.sv
// Bench for the sensor register bank: host model on the pins, engine stub here.
// Assumes the design sources and the host model are compiled first.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  typedef struct packed
  {
    logic [7:0] wr;
    logic [7:0] rd;
  } srs_row_t;
  logic        clk       = 1'h0;
  logic        rst_n     = 1'h0;
  logic        meas_busy = 1'h0;
  logic        gas_busy  = 1'h0;
  logic        gas_slot  = 1'h0;
  logic        done      = 1'h0;
  logic        skip      = 1'h0;
  logic [19:0] press     = 20'h0;
  logic [19:0] temp      = 20'h0;
  logic [15:0] hum       = 16'h0;
  logic [9:0]  gas       = 10'h0;
  logic [3:0]  rng       = 4'h0;
  logic        stab      = 1'h0;
  logic [3:0]  sel;
  logic        run;
  logic        start;
  logic        i2c_oe;
  logic        spi_o;
  logic        spi_oe;
  logic        sdo_o;
  logic        sdo_oe;
  logic        sck;
  logic        csb_n;
  logic        h_sdi;
  logic        h_sdi_oe;
  logic        h_sdo;
  logic        ack;
  logic [7:0]  r;
  logic [7:0]  exp_q [15];
  int          failures = 0;
  int          n_tests  = 0;
  srs_row_t    rows [5] = '{'{8'h00, 8'h00}, '{8'h09, 8'h09}, '{8'h13, 8'h13},
                            '{8'h1F, 8'h19}, '{8'hE5, 8'h05}};
  wire         sdi_w = i2c_oe ? 1'h0 : spi_oe ? spi_o : h_sdi_oe ? h_sdi : 1'h1;
  wire         sdo_w = sdo_oe ? sdo_o : h_sdo;

  always #10 clk = ~clk;

  srs_regbank srs_regbank_inst
  (
    .I_SYS_CLK(clk), .I_RESETN(rst_n), .I_SCK(sck), .I_CHIP_SELECT_N(csb_n),
    .I_SERIAL_IN_PIN(sdi_w), .I_SERIAL_OUT_ADDR_LSB_PIN(sdo_w),
    .I_MEAS_BUSY(meas_busy), .I_GAS_BUSY(gas_busy), .I_GAS_SLOT(gas_slot),
    .I_PHASE_DONE(done), .I_PRESS_SKIP(skip), .I_TEMP_SKIP(skip),
    .I_PRESS_RAW(press), .I_TEMP_RAW(temp), .I_HUM_RAW(hum), .I_GAS_RAW(gas),
    .I_GAS_RANGE(rng), .I_HEAT_STAB(stab), .O_HEATER_SETPOINT_SELECT(sel),
    .O_GAS_RUN_EN(run), .O_GAS_CONV_START(start), .O_SERIAL_IN_PIN_I2C_OE(i2c_oe),
    .O_SERIAL_IN_PIN_SPI_O(spi_o), .O_SERIAL_IN_PIN_SPI_OE(spi_oe),
    .O_SERIAL_OUT_ADDR_LSB_PIN_O(sdo_o), .O_SERIAL_OUT_ADDR_LSB_PIN_OE(sdo_oe)
  );

  srs_host srs_host_inst
  (
    .i_sdi(sdi_w), .i_sdo(sdo_w), .o_sck(sck), .o_csb_n(csb_n),
    .o_sdi(h_sdi), .o_sdi_oe(h_sdi_oe), .o_sdo(h_sdo)
  );

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : summarize

  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
    n_tests++;
    if (s !== e)
    begin
      failures++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  task automatic wr_reg(input logic m, input logic [7:0] a, input logic [7:0] d);
    logic [7:0] x;
    srs_host_inst.spi_begin(m);
    srs_host_inst.spi_byte(a & 8'h7F, x);
    srs_host_inst.spi_byte(d, x);
    srs_host_inst.spi_end();
  endtask : wr_reg

  task automatic rd_reg(input logic m, input logic [7:0] a, output logic [7:0] v);
    srs_host_inst.spi_begin(m);
    srs_host_inst.spi_byte(a | 8'h80, v);
    srs_host_inst.spi_byte(8'h00, v);
    srs_host_inst.spi_end();
  endtask : rd_reg

  // One frame reads status through the gas low byte, auto-incrementing.
  task automatic rd_all(input logic m);
    logic [7:0] v;
    srs_host_inst.spi_begin(m);
    srs_host_inst.spi_byte(8'h9D, v);
    foreach (exp_q[k])
    begin
      srs_host_inst.spi_byte(8'h00, v);
      chk("burst byte", exp_q[k], v);
    end
    srs_host_inst.spi_end();
  endtask : rd_all

  task automatic phase(input logic s, input logic [19:0] p, input logic [19:0] t,
                       input logic [15:0] h, input logic [9:0] g, input logic [3:0] rg,
                       input logic st);
    @(posedge clk);
    gas_slot  <= 1'h1;
    press     <= p;
    temp      <= t;
    hum       <= h;
    gas       <= g;
    rng       <= rg;
    stab      <= st;
    skip      <= s;
    @(posedge clk);
    gas_slot  <= 1'h0;
    done      <= 1'h1;
    meas_busy <= 1'h0;
    gas_busy  <= 1'h0;
    @(posedge clk);
    done      <= 1'h0;
  endtask : phase

  // The status index is the set-point written last (5); gas valid is expected set.
  task automatic mk_exp(input logic [19:0] p, input logic [19:0] t);
    exp_q = '{8'h85, 8'h00, p[19:12], p[11:4], {p[3:0], 4'h0},
              t[19:12], t[11:4], {t[3:0], 4'h0}, hum[15:8], hum[7:0],
              8'h00, 8'h00, 8'h00, gas[9:2], {gas[1:0], 1'h1, stab, rng}};
  endtask : mk_exp

  initial
  begin
    repeat (100000) @(posedge clk);
    failures++;
    summarize();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (16) @(posedge clk);
    rst_n <= 1'h1;
    repeat (4) @(posedge clk);
    chk("setpoint", 8'h00, {4'h0, sel});
    chk("outputs", 8'h00, {3'h0, run, start, i2c_oe, spi_oe, sdo_oe});
    $display("test reset done");
    srs_host_inst.i2c_addr(7'h76, 1'h0, ack);
    chk("ack low pin", 8'h01, {7'h0, ack});
    srs_host_inst.i2c_addr(7'h77, 1'h1, ack);
    chk("ack high pin", 8'h01, {7'h0, ack});
    srs_host_inst.i2c_addr(7'h77, 1'h0, ack);
    chk("ack wrong", 8'h00, {7'h0, ack});
    $display("test two-wire address done");
    // Set-up is only changed while nothing is measuring.
    foreach (rows[k])
    begin
      wr_reg(k[0], 8'h71, rows[k].wr);
      chk("setpoint", {4'h0, rows[k].rd[3:0]}, {4'h0, sel});
      chk("run enable", {7'h0, rows[k].rd[4]}, {7'h0, run});
      rd_reg(~k[0], 8'h71, r);
      chk("control", rows[k].rd, r);
    end
    $display("test control done");
    for (int n = 0; n < 2; n++)
    begin
      logic [3:0] v;
      if (n == 1)
        wr_reg(1'h0, 8'h71, 8'h15);
      @(posedge clk);
      gas_slot <= 1'h1;
      @(posedge clk);
      gas_slot <= 1'h0;
      for (int j = 0; j < 4; j++)
      begin
        @(negedge clk);
        v[j] = start;
      end
      chk("start", (n == 1) ? 8'h01 : 8'h00, {4'h0, v});
    end
    $display("test gas start done");
    @(posedge clk);
    meas_busy <= 1'h1;
    gas_busy  <= 1'h1;
    rd_reg(1'h0, 8'h1D, r);
    chk("busy flags", 8'h03, {5'h0, r[7:5]});
    phase(1'h0, 20'hABCDE, 20'h12345, 16'hBEEF, 10'h2C5, 4'hA, 1'h1);
    mk_exp(press, temp);
    rd_all(1'h0);
    $display("test results done");
    fork
      rd_all(1'h1);
      begin
        repeat (60) @(posedge clk);
        phase(1'h1, 20'h0F0F0, 20'h5A5A5, 16'h1234, 10'h13A, 4'h3, 1'h0);
      end
    join
    wr_reg(1'h1, 8'h1F, 8'hAA);
    mk_exp(20'h80000, 20'h80000);
    rd_all(1'h0);
    $display("test shadow and skip done");
    srs_host_inst.i2c_addr(7'h76, 1'h0, ack);
    chk("locked ack", 8'h00, {7'h0, ack});
    $display("test lock done");
    @(posedge clk);
    rst_n <= 1'h0;
    repeat (4) @(posedge clk);
    rst_n <= 1'h1;
    repeat (4) @(posedge clk);
    chk("setpoint reset", 8'h00, {4'h0, sel});
    srs_host_inst.i2c_addr(7'h76, 1'h0, ack);
    chk("ack after reset", 8'h01, {7'h0, ack});
    $display("test second reset done");
    summarize();
  end
endmodule : tb_top
`default_nettype wire
